/* rtl/hrd_interp.sv */
// hex record download interpreter: command line, single-line and file download
`timescale 1ns/1ps
`include "hrd_regs.svh"
// Operation
// - a line opening with colon is a record; only data records (type 00) write their data to memory
// - record format and checksum are checked before anything is accepted
// - single-line download echoes each character, carriage return as CR LF
// - lines opening with S are taken as S-records
// - file download command word plus carriage return enters file mode
// - command word is echoed, its carriage return is not
// - no echo for record characters in file mode
// - each good line in file mode is answered with 06H
// - escape or a good record of data length zero ends file mode
// - checksum or format error in file mode answers 05H
// - a start vector record loads program counter bank and counter
module hrd_interp
   import hrd_pkg::*;
(
   input  wire logic       i_core_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_rx_valid,
   output logic            o_rx_ready,
   input  wire logic [7:0] i_rx_data,
   output logic            o_tx_valid,
   input  wire logic       i_tx_ready,
   output logic [7:0]      o_tx_data,
   output logic            o_mem_we,
   output logic [23:0]     o_mem_addr,
   output logic [7:0]      o_mem_data,
   output logic            o_pc_load,
   output logic [7:0]      o_pc_bank,
   output logic [15:0]     o_pc,
   output logic            o_file_mode
);
   hrd_state_e  state_q, state_d;
   logic        file_q, file_d, srec_q, srec_d, rec_q, rec_d, ntype_q, ntype_d;
   logic        nib_q, nib_d, err_q, err_d, cbad_q, cbad_d, ok_q, ok_d, zero_q, zero_d;
   logic [3:0]  stype_q, stype_d, hi_q, hi_d;
   logic [9:0]  idx_q, idx_d;
   logic [7:0]  sum_q, sum_d, len_q, len_d, rtype_q, rtype_d, bank_q, bank_d;
   logic [7:0]  widx_q, widx_d;
   logic [2:0]  cmd_q, cmd_d;
   logic [23:0] addr_q, addr_d, maddr_q, maddr_d;
   logic [31:0] dat_q, dat_d;
   logic        mwe_q, mwe_d, pcl_q, pcl_d;
   logic [7:0]  mdat_q, mdat_d, pcb_q, pcb_d;
   logic [15:0] pc_q, pc_d;

   logic        rx_fire, push_v, txf_rdy, start, fin;
   logic        lb_push, lb_flush, lb_pop, lb_valid;
   logic [7:0]  ch, chu, push_d, lb_din, lb_dout, b, alen, dlen;
   logic [9:0]  hdr, chk;
   logic        line_ok, wr_rec, vec_rec, bank_rec;
   logic [23:0] base;
   localparam logic [47:0] CMD_WORD = `HRD_CMD_WORD;

   hrd_fifo #(.W(`HRD_BYTE_W), .D(`HRD_TXF_DEPTH)) u_txf (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_flush    (1'b0),
      .i_in_valid (push_v),
      .o_in_ready (txf_rdy),
      .i_in_data  (push_d),
      .o_out_valid(o_tx_valid),
      .i_out_ready(i_tx_ready),
      .o_out_data (o_tx_data)
   );

   // whole line is held back so a late error can still discard it
   hrd_fifo #(.W(`HRD_BYTE_W), .D(`HRD_LBUF_DEPTH)) u_lbuf (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_flush    (lb_flush),
      .i_in_valid (lb_push),
      .o_in_ready (),
      .i_in_data  (lb_din),
      .o_out_valid(lb_valid),
      .i_out_ready(lb_pop),
      .o_out_data (lb_dout)
   );

   assign ch         = i_rx_data;
   assign chu        = hrd_upper(i_rx_data);
   assign o_rx_ready = (state_q == ST_CMD || state_q == ST_REC || state_q == ST_FWAIT) && txf_rdy;
   assign rx_fire    = i_rx_valid && o_rx_ready;
   assign b          = {hi_q, hrd_hex_val(ch)};
   assign o_mem_we   = mwe_q;
   assign o_mem_addr = maddr_q;
   assign o_mem_data = mdat_q;
   assign o_pc_load  = pcl_q;
   assign o_pc_bank  = pcb_q;
   assign o_pc       = pc_q;
   assign o_file_mode = file_q;

   always_comb begin
      unique case (stype_q)
         4'h2, 4'h8: alen = 8'h03;
         4'h3, 4'h7: alen = 8'h04;
         default:    alen = 8'h02;
      endcase
      if (!srec_q) begin
         alen = `HRD_I_ADDR_LEN;
      end
      hdr  = srec_q ? 10'(alen) + 10'h001 : `HRD_I_HDR;
      dlen = srec_q ? len_q - alen - 8'h01 : len_q;
      chk  = hdr + 10'(dlen);
      base = srec_q ? addr_q : {bank_q, addr_q[15:0]};
      line_ok = rec_q && !err_q && !nib_q && !ntype_q && idx_q == chk + 10'h001 &&
                sum_q == (srec_q ? `HRD_S_SUM : `HRD_I_SUM) &&
                !(srec_q && len_q <= alen);
      wr_rec   = srec_q ? (stype_q >= 4'h1 && stype_q <= 4'h3) : rtype_q == `HRD_IT_DATA;
      vec_rec  = srec_q ? (stype_q >= 4'h7 && stype_q <= 4'h9) : rtype_q == `HRD_IT_VEC;
      bank_rec = !srec_q && rtype_q == `HRD_IT_BANK;
   end

   always_comb begin
      state_d = state_q;  file_d = file_q;   srec_d = srec_q;   rec_d = rec_q;
      ntype_d = ntype_q;  nib_d = nib_q;     err_d = err_q;     cbad_d = cbad_q;
      ok_d = ok_q;        zero_d = zero_q;   stype_d = stype_q; hi_d = hi_q;
      idx_d = idx_q;      sum_d = sum_q;     len_d = len_q;     rtype_d = rtype_q;
      bank_d = bank_q;    widx_d = widx_q;   cmd_d = cmd_q;     addr_d = addr_q;
      dat_d = dat_q;      maddr_d = maddr_q; mdat_d = mdat_q;   pcb_d = pcb_q;
      pc_d = pc_q;        mwe_d = 1'b0;      pcl_d = 1'b0;
      push_v = 1'b0;  push_d = ch;  start = 1'b0;  fin = 1'b0;
      lb_push = 1'b0; lb_din = b;   lb_flush = 1'b0; lb_pop = 1'b0;
      unique case (state_q)
         ST_CMD: if (rx_fire) begin
            if (ch == `HRD_CH_CR) begin
               if (cmd_q == `HRD_CMD_LEN && !cbad_q) begin
                  file_d  = 1'b1;
                  state_d = ST_FWAIT;
               end else begin
                  push_v  = 1'b1;
                  state_d = ST_LF;
               end
               cmd_d  = '0;
               cbad_d = 1'b0;
            end else if (cmd_q == '0 && !cbad_q && (ch == `HRD_CH_COLON || chu == `HRD_CH_S)) begin
               push_v = 1'b1;
               start  = 1'b1;
            end else begin
               push_v = hrd_is_print(ch);
               if (cmd_q != `HRD_CMD_LEN && chu == CMD_WORD[47 - 8 * cmd_q -: 8]) begin
                  cmd_d = cmd_q + 3'h1;
               end else begin
                  cbad_d = 1'b1;
               end
            end
         end
         ST_REC: if (rx_fire) begin
            push_v = !file_q;
            if (ch == `HRD_CH_ESC && file_q) begin
               file_d   = 1'b0;
               rec_d    = 1'b0;
               lb_flush = 1'b1;
               state_d  = ST_CMD;
            end else if (ch == `HRD_CH_CR) begin
               state_d = file_q ? ST_DRAIN : ST_LF;
            end else if (ch == `HRD_CH_LF) begin
               state_d = ST_REC;
            end else if (ntype_q) begin
               ntype_d = 1'b0;
               stype_d = ch[3:0];
               err_d   = !(ch >= 8'h30 && ch <= 8'h39);
            end else if (!hrd_is_hex(ch)) begin
               err_d = 1'b1;
            end else if (!nib_q) begin
               nib_d = 1'b1;
               hi_d  = hrd_hex_val(ch);
            end else begin
               nib_d = 1'b0;
               sum_d = sum_q + b;
               idx_d = (idx_q == 10'h3ff) ? idx_q : idx_q + 10'h001;
               if (idx_q == '0) begin
                  len_d = b;
               end else if (idx_q < hdr) begin
                  if (!srec_q && idx_q == `HRD_I_TYPE_IDX) begin
                     rtype_d = b;
                  end else begin
                     addr_d = {addr_q[15:0], b};
                  end
               end else if (idx_q < chk) begin
                  lb_push = 1'b1;
                  dat_d   = {dat_q[23:0], b};
               end else if (idx_q > chk) begin
                  err_d = 1'b1;
               end
            end
         end
         ST_LF: begin
            push_v = 1'b1;
            push_d = `HRD_CH_LF;
            if (txf_rdy) begin
               state_d = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (line_ok && wr_rec && lb_valid) begin
               lb_pop  = 1'b1;
               mwe_d   = 1'b1;
               // colon records wrap inside their bank, never carry into it
               maddr_d = srec_q ? base + {16'h0000, widx_q}
                                : {bank_q, addr_q[15:0] + {8'h00, widx_q}};
               mdat_d  = lb_dout;
               widx_d  = widx_q + 8'h01;
            end else begin
               fin      = 1'b1;
               lb_flush = 1'b1;
               rec_d    = 1'b0;
               ok_d     = line_ok;
               zero_d   = dlen == 8'h00;
               if (line_ok && bank_rec) begin
                  bank_d = dat_q[7:0];
               end
               if (line_ok && vec_rec) begin
                  pcl_d = 1'b1;
                  pcb_d = srec_q ? addr_q[23:16] : dat_q[23:16];
                  pc_d  = srec_q ? addr_q[15:0] : dat_q[15:0];
               end
               state_d = file_q ? ST_RESP : ST_CMD;
            end
         end
         ST_RESP: begin
            push_v = 1'b1;
            push_d = ok_q ? `HRD_CH_ACK : `HRD_CH_NAK;
            if (txf_rdy) begin
               file_d  = !(ok_q && zero_q);
               state_d = (ok_q && zero_q) ? ST_CMD : ST_FWAIT;
            end
         end
         ST_FWAIT: if (rx_fire) begin
            if (ch == `HRD_CH_ESC) begin
               file_d  = 1'b0;
               state_d = ST_CMD;
            end else if (ch == `HRD_CH_COLON || chu == `HRD_CH_S) begin
               start = 1'b1;
            end
         end
         default: state_d = ST_CMD;
      endcase
      if (start) begin
         state_d = ST_REC;  srec_d = ch != `HRD_CH_COLON;  ntype_d = ch != `HRD_CH_COLON;
         rec_d = 1'b1;      nib_d = 1'b0;  err_d = 1'b0;   idx_d = '0;   sum_d = '0;
         len_d = '0;        rtype_d = '0;  stype_d = '0;   addr_d = '0;  dat_d = '0;
         widx_d = '0;       lb_flush = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= ST_CMD; file_q <= 1'b0; srec_q <= 1'b0; rec_q <= 1'b0;
         ntype_q <= 1'b0;   nib_q <= 1'b0;  err_q <= 1'b0;  cbad_q <= 1'b0;
         ok_q <= 1'b0;      zero_q <= 1'b0; stype_q <= '0;  hi_q <= '0;
         idx_q <= '0;       sum_q <= '0;    len_q <= '0;    rtype_q <= '0;
         bank_q <= '0;      widx_q <= '0;   cmd_q <= '0;    addr_q <= '0;
         dat_q <= '0;       maddr_q <= '0;  mdat_q <= '0;   pcb_q <= '0;
         pc_q <= '0;        mwe_q <= 1'b0;  pcl_q <= 1'b0;
      end else begin
         state_q <= state_d; file_q <= file_d; srec_q <= srec_d; rec_q <= rec_d;
         ntype_q <= ntype_d; nib_q <= nib_d;   err_q <= err_d;   cbad_q <= cbad_d;
         ok_q <= ok_d;       zero_q <= zero_d; stype_q <= stype_d; hi_q <= hi_d;
         idx_q <= idx_d;     sum_q <= sum_d;   len_q <= len_d;   rtype_q <= rtype_d;
         bank_q <= bank_d;   widx_q <= widx_d; cmd_q <= cmd_d;   addr_q <= addr_d;
         dat_q <= dat_d;     maddr_q <= maddr_d; mdat_q <= mdat_d; pcb_q <= pcb_d;
         pc_q <= pc_d;       mwe_q <= mwe_d;   pcl_q <= pcl_d;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   a_write_checked: assert property (
      o_mem_we |-> $past(line_ok && wr_rec && state_q == ST_DRAIN))
      else $error("memory written from an unchecked record");
   a_write_bank: assert property (
      o_mem_we && !srec_q |-> o_mem_addr[23:16] == bank_q)
      else $error("colon record written outside current bank");
   a_line_echo: assert property (
      rx_fire && state_q == ST_REC && !file_q |-> push_v && push_d == ch)
      else $error("single-line character not echoed");
   a_cr_lf: assert property (
      rx_fire && state_q == ST_REC && !file_q && ch == `HRD_CH_CR
      |-> push_v ##1 (state_q == ST_LF && push_v && push_d == `HRD_CH_LF))
      else $error("carriage return not answered with cr lf");
   a_s_start: assert property (
      rx_fire && state_q == ST_FWAIT && ch == `HRD_CH_S |=> state_q == ST_REC && srec_q)
      else $error("s line not started as s-record");
   a_cmd_enter: assert property (
      rx_fire && state_q == ST_CMD && ch == `HRD_CH_CR && cmd_q == `HRD_CMD_LEN && !cbad_q
      |-> !push_v ##1 (file_q && state_q == ST_FWAIT))
      else $error("command carriage return echoed or mode not entered");
   a_file_quiet: assert property (
      file_q && (state_q == ST_REC || state_q == ST_FWAIT) |-> !push_v)
      else $error("echo in file mode");
   a_ack_nak: assert property (
      fin && file_q |=> push_v && push_d == ($past(line_ok) ? `HRD_CH_ACK : `HRD_CH_NAK))
      else $error("wrong line answer");
   a_esc_exit: assert property (
      rx_fire && file_q && ch == `HRD_CH_ESC |=> !file_q && state_q == ST_CMD)
      else $error("escape did not end file mode");
   a_vec_load: assert property (
      fin && line_ok && vec_rec |=> o_pc_load ##1 !o_pc_load)
      else $error("start vector not loaded as one pulse");
   a_bad_char: assert property (
      rx_fire && state_q == ST_REC && !ntype_q && !hrd_is_hex(ch) && ch != `HRD_CH_CR &&
      ch != `HRD_CH_LF && ch != `HRD_CH_ESC |=> err_q && !line_ok)
      else $error("bad character did not spoil the line");

   c_mem_write: cover property (o_mem_we ##1 !o_mem_we);
   c_file_ack:  cover property (push_v && push_d == `HRD_CH_ACK && txf_rdy);
   c_file_nak:  cover property (push_v && push_d == `HRD_CH_NAK && txf_rdy);
   c_pc_load:   cover property (o_pc_load);
endmodule : hrd_interp

/* rtl/hrd_regs.svh */
// character codes, record layout constants and buffer sizes of the hex record interpreter
`ifndef HRD_REGS_SVH
`define HRD_REGS_SVH
`define HRD_CH_CR       8'h0d
`define HRD_CH_LF       8'h0a
`define HRD_CH_ESC      8'h1b
`define HRD_CH_COLON    8'h3a
`define HRD_CH_S        8'h53
`define HRD_CH_ACK      8'h06
`define HRD_CH_NAK      8'h05
`define HRD_CMD_WORD    48'h48_45_58_44_57_4c
`define HRD_CMD_LEN     3'h6
`define HRD_I_HDR       10'h004
`define HRD_I_TYPE_IDX  10'h003
`define HRD_I_ADDR_LEN  8'h02
`define HRD_IT_DATA     8'h00
`define HRD_IT_BANK     8'h04
`define HRD_IT_VEC      8'h05
`define HRD_I_SUM       8'h00
`define HRD_S_SUM       8'hff
`define HRD_TXF_DEPTH   8
`define HRD_LBUF_DEPTH  256
`define HRD_BYTE_W      8
`endif

/* rtl/hrd_pkg.sv */
// types and character helpers of the hex record interpreter
package hrd_pkg;
   typedef enum logic [2:0] {
      ST_CMD   = 3'b000,
      ST_REC   = 3'b001,
      ST_LF    = 3'b011,
      ST_DRAIN = 3'b010,
      ST_RESP  = 3'b110,
      ST_FWAIT = 3'b111
   } hrd_state_e;

   function automatic logic hrd_is_hex(input logic [7:0] c);
      return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46) ||
             (c >= 8'h61 && c <= 8'h66);
   endfunction : hrd_is_hex

   function automatic logic [3:0] hrd_hex_val(input logic [7:0] c);
      return (c <= 8'h39) ? c[3:0] : c[3:0] + 4'h9;
   endfunction : hrd_hex_val

   function automatic logic [7:0] hrd_upper(input logic [7:0] c);
      return (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
   endfunction : hrd_upper

   function automatic logic hrd_is_print(input logic [7:0] c);
      return c >= 8'h20 && c < 8'h7f;
   endfunction : hrd_is_print
endpackage : hrd_pkg

/* rtl/hrd_fifo.sv */
// byte fifo with registered read data, used for transmit and record line buffering
`timescale 1ns/1ps
module hrd_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_flush,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic [W-1:0]  rd_q, rd_d;
   logic          push, pop;

   assign o_in_ready  = cnt_q != D[AW:0];
   assign o_out_valid = cnt_q != '0;
   assign o_out_data  = rd_q;
   assign push        = i_in_valid && o_in_ready && !i_flush;
   assign pop         = o_out_valid && i_out_ready && !i_flush;

   always_comb begin
      wp_d  = wp_q + AW'(push);
      rp_d  = rp_q + AW'(pop);
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      // bypass keeps the head register right when the write hits the next head
      rd_d  = (push && wp_q == rp_d) ? i_in_data : mem_q[rp_d];
      if (i_flush) begin
         wp_d  = '0;
         rp_d  = '0;
         cnt_d = '0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem_q[wp_q] <= i_in_data;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
         rd_q  <= '0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
         rd_q  <= rd_d;
      end
   end
endmodule : hrd_fifo

/* sim/hrd_host.sv */
// host-side download program model: sends terminal bytes and collects the replies
`timescale 1ns/1ps
module hrd_host (
   input  wire logic       i_core_clk,
   input  wire logic       i_stall,
   output logic            o_rx_valid,
   input  wire logic       i_rx_ready,
   output logic [7:0]      o_rx_data,
   input  wire logic       i_tx_valid,
   output logic            o_tx_ready,
   output int              o_seen,
   output int              o_errs
);
   int want;

   initial begin
      o_rx_valid = 1'b0;
      o_rx_data  = 8'h00;
      o_tx_ready = 1'b0;
      o_seen     = 0;
      o_errs     = 0;
      want       = 0;
   end

   // stalls come from the bench so the echo path sees back pressure
   // loader rate changes show up only as these stalls at byte level
   always @(negedge i_core_clk) begin
      o_tx_ready <= !i_stall;
   end

   always @(posedge i_core_clk) begin
      if (i_tx_valid && o_tx_ready) begin
         o_seen <= o_seen + 1;
      end
   end

   // one byte, then wait for n_resp reply bytes before going on
   task automatic put(input logic [7:0] b, input int n_resp);
      int k;
      @(negedge i_core_clk);
      o_rx_valid = 1'b1;
      o_rx_data  = b;
      #1;
      k = 0;
      while (!i_rx_ready && k < 500) begin
         @(negedge i_core_clk);
         #1;
         k++;
      end
      @(posedge i_core_clk);
      @(negedge i_core_clk);
      o_rx_valid = 1'b0;
      o_rx_data  = ~b; // released line shows no stale byte
      want += n_resp;
      while (o_seen < want && k < 2500) begin
         @(negedge i_core_clk);
         k++;
      end
      if (k >= 500) begin
         o_errs++;
      end
   endtask : put
endmodule : hrd_host

/* sim/testbench.sv */
// self-checking bench of the hex record interpreter with a host model
`timescale 1ns/1ps
`include "hrd_regs.svh"
`define CHK(g, e) check(32'(g), 32'(e))
module testbench;
   logic              i_core_clk;
   logic              i_sys_rst;
   logic              rx_valid, rx_ready, tx_valid, tx_ready, stall;
   logic              mem_we, pc_load, file_mode;
   logic [7:0]        rx_data, tx_data, mem_data, pc_bank, bank;
   logic [23:0]       mem_addr;
   logic [15:0]       pc;
   logic [31:0]       rnd;
   logic [7:0]        dat[$];
   logic [31:0]       exp_tx[$], exp_mem[$], exp_pc[$];
   int                host_seen, host_errs, miscompares, num_checks;

   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   hrd_interp DUT (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_rx_valid(rx_valid),
      .o_rx_ready(rx_ready), .i_rx_data(rx_data), .o_tx_valid(tx_valid),
      .i_tx_ready(tx_ready), .o_tx_data(tx_data), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
      .o_mem_data(mem_data), .o_pc_load(pc_load), .o_pc_bank(pc_bank), .o_pc(pc),
      .o_file_mode(file_mode));

   hrd_host host (.i_core_clk(i_core_clk), .i_stall(stall), .o_rx_valid(rx_valid),
      .i_rx_ready(rx_ready), .o_rx_data(rx_data), .i_tx_valid(tx_valid),
      .o_tx_ready(tx_ready), .o_seen(host_seen), .o_errs(host_errs));

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   // only this process advances the generator, so draws stay deterministic
   always @(negedge i_core_clk) begin
      rnd   <= xs(rnd);
      stall <= (rnd[3:2] == 2'b00);
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic take(ref logic [31:0] q[$], input logic [31:0] got);
      check(got, (q.size() > 0) ? q.pop_front() : 32'hxxxxxxxx);
   endtask : take

   always @(posedge i_core_clk) begin
      if (!i_sys_rst && tx_valid && tx_ready) begin
         take(exp_tx, {24'h0, tx_data});
      end
      if (!i_sys_rst && mem_we) begin
         take(exp_mem, {mem_addr, mem_data});
      end
      if (!i_sys_rst && pc_load) begin
         take(exp_pc, {8'h00, pc_bank, pc});
      end
   end

   task automatic end_of_test();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic fill(input int n);
      dat.delete();
      repeat (n) begin
         @(negedge i_core_clk);
         dat.push_back(rnd[15:8]);
      end
   endtask : fill

   // wait until every noted result has shown up, bounded
   task automatic settle();
      int k;
      k = 0;
      while ((exp_tx.size() + exp_mem.size() + exp_pc.size()) != 0 && k < 2000) begin
         @(negedge i_core_clk);
         k++;
      end
      repeat (4) @(negedge i_core_clk);
   endtask : settle

   // err: 0 good, 1 wrong checksum, 2 non-hex digit in the body
   task automatic send_rec(input string s, input bit file, input int err);
      if (err == 2) begin
         s.putc(9, "g");
      end
      for (int i = 0; i < s.len(); i++) begin
         if (!file) begin
            exp_tx.push_back(32'(s[i]));
         end
         host.put(s[i], file ? 0 : 1);
      end
      if (!file) begin
         exp_tx.push_back({24'h0, `HRD_CH_CR});
         exp_tx.push_back({24'h0, `HRD_CH_LF});
      end else begin
         exp_tx.push_back({24'h0, (err != 0) ? `HRD_CH_NAK : `HRD_CH_ACK});
      end
      host.put(`HRD_CH_CR, file ? 1 : 2);
   endtask : send_rec

   task automatic intel(input logic [7:0] typ, input logic [15:0] a, input bit file,
                        input int err);
      string      s;
      logic [7:0] sum;
      s   = $sformatf(":%02X%04X%02X", dat.size(), a, typ);
      sum = 8'(dat.size()) + a[15:8] + a[7:0] + typ;
      foreach (dat[i]) begin
         s = {s, $sformatf("%02X", dat[i])};
         sum += dat[i];
      end
      s = {s, $sformatf("%02X", 8'(-sum) + 8'(err == 1))};
      if (err == 0 && typ == 8'h00) begin
         foreach (dat[i]) exp_mem.push_back({bank, a + 16'(i), dat[i]});
      end
      if (err == 0 && typ == 8'h04) begin
         bank = dat[1];
      end
      if (err == 0 && typ == 8'h05) begin
         exp_pc.push_back({8'h00, dat[1], dat[2], dat[3]});
      end
      send_rec(s, file, err);
   endtask : intel

   // t: 1-3 data, 7-9 start vector; address width follows the type
   task automatic srec(input logic [3:0] t, input logic [23:0] a, input bit file);
      string       s;
      logic [7:0]  sum;
      logic [31:0] aw;
      int          al;
      aw  = {8'h00, a};
      al  = (t == 4'h1 || t == 4'h9) ? 2 : (t == 4'h2 || t == 4'h8) ? 3 : 4;
      s   = $sformatf("S%1X%02X", t, dat.size() + al + 1);
      sum = 8'(dat.size() + al + 1);
      for (int j = al - 1; j >= 0; j--) begin
         s   = {s, $sformatf("%02X", aw[j*8 +: 8])};
         sum += aw[j*8 +: 8];
      end
      foreach (dat[i]) begin
         s = {s, $sformatf("%02X", dat[i])};
         sum += dat[i];
         if (t <= 4'h3) begin
            exp_mem.push_back({a + 24'(i), dat[i]});
         end
      end
      if (t >= 4'h7) begin
         exp_pc.push_back({8'h00, a});
      end
      s = {s, $sformatf("%02X", ~sum)};
      send_rec(s, file, 0);
   endtask : srec

   task automatic enter_file();
      logic [47:0] cmd;
      cmd = `HRD_CMD_WORD;
      for (int i = 5; i >= 0; i--) begin
         exp_tx.push_back({24'h0, cmd[i*8 +: 8]});
         host.put(cmd[i*8 +: 8], 1);
      end
      host.put(`HRD_CH_CR, 0);
      settle();
      `CHK(file_mode, 1'b1);
   endtask : enter_file

   initial begin
      #500_000;
      miscompares++;
      end_of_test();
   end

   initial begin
      i_sys_rst   = 1'b1;
      stall       = 1'b0;
      rnd         = 32'h4494;
      bank        = 8'h00;
      miscompares = 0;
      num_checks  = 0;
      repeat (3) @(negedge i_core_clk);
      i_sys_rst = 1'b0;
      dat = '{8'h00, 8'h12};
      intel(8'h04, 16'h0000, 0, 0);
      fill(16);
      intel(8'h00, 16'h2000, 0, 0);
      fill(4);
      intel(8'h00, 16'h3000, 0, 1);
      fill(4);
      intel(8'h00, 16'h3000, 0, 2);
      fill(3);
      srec(4'h2, 24'h1f0040, 0);
      fill(2);
      srec(4'h1, 24'h005000, 0);
      dat.delete();
      srec(4'h8, 24'h0a1234, 0);
      fill(4);
      intel(8'h00, 16'hfffe, 0, 0);
      settle();
      $display("test single_line done");
      enter_file();
      fill(8);
      intel(8'h00, 16'h4000, 1, 0);
      fill(5);
      intel(8'h00, 16'h4100, 1, 1);
      fill(5);
      intel(8'h00, 16'h4200, 1, 2);
      fill(6);
      srec(4'h2, 24'h2a0100, 1);
      dat = '{8'h00, 8'h0f, 8'h12, 8'h34};
      intel(8'h05, 16'h0000, 1, 0);
      dat.delete();
      intel(8'h01, 16'h0000, 1, 0);
      settle();
      `CHK(file_mode, 1'b0);
      $display("test file_download done");
      enter_file();
      host.put(`HRD_CH_ESC, 0);
      settle();
      `CHK(file_mode, 1'b0);
      `CHK(exp_tx.size() + exp_mem.size() + exp_pc.size() + host_errs, 0);
      $display("test escape_exit done");
      end_of_test();
   end
endmodule : testbench
